//--- logic/flc_fetch_cache.sv
// flc_fetch_cache: flash read strobe timing, prefetch engine, branch target cache
module flc_fetch_cache #(
	parameter int ENTRIES = flc_pkg::CACHE_ENTRIES,
	parameter int PTR_W   = $clog2(ENTRIES)
) (
	input  wire logic                       clock_in,
	input  wire logic                       srst_in,
	flc_link_if.dev                         link,
	output logic                            flash_strobe_out,
	output logic [flc_pkg::TAG_W-1:0]       flash_word_addr_out,
	input  wire logic [flc_pkg::WORD_W-1:0] flash_data_in
);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(ENTRIES - 1);

	// register state
	logic [1:0]                 rt_q, rt_d;       // read_time_field
	logic [2:0]                 cc_q, cc_d;       // wren, rden, pfen
	// flash access state
	flc_pkg::flc_fl_state_t     st_q, st_d;       // strobe state
	logic [1:0]                 cnt_q, cnt_d;     // strobe cycles left
	logic [flc_pkg::TAG_W-1:0]  rd_tag_q, rd_tag_d; // word under read
	logic                       pf_q, pf_d;       // read is a prefetch
	logic                       wait_q, wait_d;   // core stalled on read
	logic [flc_pkg::OFF_W-1:0]  off_q, off_d;     // byte the core wants
	// linear slot and prefetched next word
	logic [flc_pkg::TAG_W-1:0]  lin_tag_q, lin_tag_d;
	logic [flc_pkg::WORD_W-1:0] lin_q, lin_d;
	logic                       lin_val_q, lin_val_d;
	logic [flc_pkg::TAG_W-1:0]  nxt_tag_q, nxt_tag_d;
	logic [flc_pkg::WORD_W-1:0] nxt_q, nxt_d;
	logic                       nxt_val_q, nxt_val_d;
	// branch target cache arrays
	logic [flc_pkg::TAG_W-1:0]  tag_q [ENTRIES];  // 13-bit tags
	logic [flc_pkg::WORD_W-1:0] slot_q [ENTRIES]; // four bytes each
	logic [ENTRIES-1:0]         val_q, val_d;     // valid bits
	logic [PTR_W-1:0]           ptr_q, ptr_d;     // rebound replacement
	logic                       up_q, up_d;       // rebound direction
	logic                       cwe;              // cache write strobe
	// answer to the core
	logic                       rv_q, rv_d;
	logic [7:0]                 rdat_q, rdat_d;
	// lookup
	logic [flc_pkg::TAG_W-1:0]  req_tag;
	logic [flc_pkg::OFF_W-1:0]  req_off;
	logic                       c_hit;
	logic [flc_pkg::WORD_W-1:0] c_word;
	logic                       rd_done;

	// pick one byte out of a word
	function automatic logic [7:0] byte_of(input logic [flc_pkg::WORD_W-1:0] w,
		input logic [flc_pkg::OFF_W-1:0] o);
		byte_of = w[{o, 3'b000} +: 8];
	endfunction : byte_of

	assign req_tag = link.req_addr[flc_pkg::ADDR_W-1:flc_pkg::OFF_W];
	assign req_off = link.req_addr[flc_pkg::OFF_W-1:0];
	assign rd_done = (st_q == flc_pkg::FL_READ) && (cnt_q == 2'h0);

	// compare the request against every valid cache tag
	always_comb begin
		c_hit  = 1'b0;
		c_word = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (val_q[i] && tag_q[i] == req_tag) begin
				c_hit  = 1'b1;
				c_word = slot_q[i];
			end
		end
	end

	// next state for registers, flash access, prefetch and answers
	always_comb begin
		rt_d      = rt_q;
		cc_d      = cc_q;
		st_d      = st_q;
		cnt_d     = cnt_q;
		rd_tag_d  = rd_tag_q;
		pf_d      = pf_q;
		wait_d    = wait_q;
		off_d     = off_q;
		lin_tag_d = lin_tag_q;
		lin_d     = lin_q;
		lin_val_d = lin_val_q;
		nxt_tag_d = nxt_tag_q;
		nxt_d     = nxt_q;
		nxt_val_d = nxt_val_q;
		rv_d      = 1'b0;
		rdat_d    = rdat_q;
		cwe       = 1'b0;
		// software register writes; unused and reserved bits dropped
		if (link.ctl_wr && link.ctl_sel == flc_pkg::SEL_TIMING) begin
			rt_d = link.ctl_wdata[flc_pkg::RT_MSB:flc_pkg::RT_LSB];
		end
		if (link.ctl_wr && link.ctl_sel == flc_pkg::SEL_CACHE) begin
			cc_d = link.ctl_wdata[flc_pkg::CC_WREN:flc_pkg::CC_PFEN];
		end
		// strobe countdown and read completion
		if (rd_done) begin
			st_d = flc_pkg::FL_IDLE;
			if (!pf_q || wait_q) begin
				// demand read: word goes to the linear slot
				lin_d     = flash_data_in;
				lin_tag_d = rd_tag_q;
				lin_val_d = 1'b1;
				cwe       = wait_q && cc_q[2];
				if (wait_q) begin
					rv_d   = 1'b1;
					rdat_d = byte_of(flash_data_in, off_q);
					wait_d = 1'b0;
				end
			end else begin
				// prefetch read: park as the next word
				nxt_d     = flash_data_in;
				nxt_tag_d = rd_tag_q;
				nxt_val_d = 1'b1;
			end
		end else if (st_q == flc_pkg::FL_READ) begin
			cnt_d = cnt_q - 2'h1;
			// a prefetch the core is not waiting on stops as soon as it is disabled
			if (pf_q && !wait_q && !cc_q[0]) begin
				st_d = flc_pkg::FL_IDLE;
			end
		end
		// core request, taken while not stalled
		if (link.req && !wait_q) begin
			if (c_hit && cc_q[1]) begin
				rv_d   = 1'b1;
				rdat_d = byte_of(c_word, req_off);
			end else if (lin_val_q && lin_tag_q == req_tag) begin
				rv_d   = 1'b1;
				rdat_d = byte_of(lin_q, req_off);
			end else if (nxt_val_q && nxt_tag_q == req_tag) begin
				// sequential step: next word becomes current
				rv_d      = 1'b1;
				rdat_d    = byte_of(nxt_q, req_off);
				lin_d     = nxt_q;
				lin_tag_d = nxt_tag_q;
				lin_val_d = 1'b1;
				nxt_val_d = 1'b0;
			end else if (st_q == flc_pkg::FL_READ && rd_tag_q == req_tag) begin
				if (rd_done) begin
					rv_d   = 1'b1;
					rdat_d = byte_of(flash_data_in, req_off);
				end else begin
					st_d   = flc_pkg::FL_READ; // keep a read the core now waits on
					wait_d = 1'b1;
					off_d  = req_off;
				end
			end else begin
				// full miss: abandon any prefetch and read this word
				st_d     = flc_pkg::FL_READ;
				cnt_d    = rt_q;
				rd_tag_d = req_tag;
				pf_d     = 1'b0;
				wait_d   = 1'b1;
				off_d    = req_off;
			end
		end
		// launch a prefetch of the word after the linear slot
		if (st_d == flc_pkg::FL_IDLE && cc_d[0] && lin_val_d &&
			!(nxt_val_d && nxt_tag_d == flc_pkg::TAG_W'(lin_tag_d + 1'b1))) begin
			st_d     = flc_pkg::FL_READ;
			cnt_d    = rt_d;
			rd_tag_d = flc_pkg::TAG_W'(lin_tag_d + 1'b1);
			pf_d     = 1'b1;
		end
	end

	// rebound replacement: walk up to the end, then back down
	always_comb begin
		ptr_d = ptr_q;
		up_d  = up_q;
		val_d = val_q;
		if (cwe) begin
			val_d[ptr_q] = 1'b1;
			if (up_q) begin
				if (ptr_q == PTR_LAST) begin
					up_d  = 1'b0;
					ptr_d = ptr_q - 1'b1;
				end else begin
					ptr_d = ptr_q + 1'b1;
				end
			end else begin
				if (ptr_q == '0) begin
					up_d  = 1'b1;
					ptr_d = ptr_q + 1'b1;
				end else begin
					ptr_d = ptr_q - 1'b1;
				end
			end
		end
	end

	// register control, access and answer state
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rt_q      <= flc_pkg::RT_RST;
			cc_q      <= flc_pkg::CC_RST;
			st_q      <= flc_pkg::FL_IDLE;
			cnt_q     <= '0;
			rd_tag_q  <= '0;
			pf_q      <= 1'b0;
			wait_q    <= 1'b0;
			off_q     <= '0;
			lin_tag_q <= '0;
			lin_q     <= '0;
			lin_val_q <= 1'b0;
			nxt_tag_q <= '0;
			nxt_q     <= '0;
			nxt_val_q <= 1'b0;
			rv_q      <= 1'b0;
			rdat_q    <= '0;
			val_q     <= '0;
			ptr_q     <= '0;
			up_q      <= 1'b1;
		end else begin
			rt_q      <= rt_d;
			cc_q      <= cc_d;
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			rd_tag_q  <= rd_tag_d;
			pf_q      <= pf_d;
			wait_q    <= wait_d;
			off_q     <= off_d;
			lin_tag_q <= lin_tag_d;
			lin_q     <= lin_d;
			lin_val_q <= lin_val_d;
			nxt_tag_q <= nxt_tag_d;
			nxt_q     <= nxt_d;
			nxt_val_q <= nxt_val_d;
			rv_q      <= rv_d;
			rdat_q    <= rdat_d;
			val_q     <= val_d;
			ptr_q     <= ptr_d;
			up_q      <= up_d;
		end
	end

	// cache slot storage, no reset needed behind the valid bits
	always_ff @(posedge clock_in) begin
		if (cwe) begin
			tag_q[ptr_q]  <= rd_tag_q;
			slot_q[ptr_q] <= flash_data_in;
		end
	end

	// flash array sees the strobe; it is idle otherwise
	assign flash_strobe_out    = (st_q == flc_pkg::FL_READ);
	assign flash_word_addr_out = rd_tag_q;
	// link outputs
	assign link.stall      = wait_q;
	assign link.resp_valid = rv_q;
	assign link.resp_data  = rdat_q;
	assign link.timing_reg = {2'b00, rt_q, 4'h0};
	assign link.cache_reg  = {cc_q, 5'h00};
endmodule : flc_fetch_cache

//--- inc/flc_pkg.sv
// flc_pkg: shared constants and types for the flash fetch timing cache
package flc_pkg;
	// code space and cache geometry
	localparam int ADDR_W = 15;               // byte address into 32 kB code flash
	localparam int OFF_W  = 2;                // byte within a four-byte word
	localparam int TAG_W  = ADDR_W - OFF_W;   // 13-bit word tag
	localparam int WORD_W = 32;               // four code bytes
	localparam int CACHE_ENTRIES = 32;        // branch target cache depth
	// flash_read_timing_ctrl layout
	localparam int RT_LSB = 4;                 // read_time_field low bit
	localparam int RT_MSB = 5;                 // read_time_field high bit
	localparam logic [1:0] RT_RST = 2'h0;      // 25 MHz or slower
	localparam logic [1:0] RT_MIN = 2'h0;      // code 00, clock up to 25 MHz
	// cache_control_reg layout
	localparam int CC_WREN = 7;                // cache writes enable
	localparam int CC_RDEN = 6;                // cache reads enable
	localparam int CC_PFEN = 5;                // prefetch_enable_bit
	localparam logic [2:0] CC_RST = 3'h7;      // all three enabled at reset
	// register select on the link
	localparam logic SEL_TIMING = 1'b0;
	localparam logic SEL_CACHE  = 1'b1;
	// host avalon word indices
	localparam logic [1:0] AV_FETCH = 2'h0;
	localparam logic [1:0] AV_CLOCK = 2'h1;
	localparam logic [1:0] AV_CACHE = 2'h2;
	localparam int ST_DONE = 8;                // fetch status: answer present
	localparam int ST_BUSY = 9;                // fetch status: fetch outstanding
	localparam int CK_BUSY = 2;                // clock status: sequence running
	localparam int CK_TREG = 8;                // clock status: timing reg copy
	// device flash access states
	typedef enum logic {
		FL_IDLE = 1'b0,
		FL_READ = 1'b1
	} flc_fl_state_t;
	// host read-time update sequence, gray from SQ_IDLE through SQ_ON; the step back to SQ_IDLE flips two bits
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_DROP = 3'b001,
		SQ_OFF  = 3'b011,
		SQ_SET  = 3'b010,
		SQ_ON   = 3'b110
	} flc_seq_state_t;
endpackage : flc_pkg

//--- inc/flc_link_if.sv
// flc_link_if: link between the core side and the fetch cache
interface flc_link_if;
	logic                        req;        // fetch request, one cycle
	logic [flc_pkg::ADDR_W-1:0]  req_addr;   // fetch byte address
	logic                        stall;      // device waiting on flash
	logic                        resp_valid; // fetch answer, one cycle
	logic [7:0]                  resp_data;  // fetched byte
	logic                        ctl_wr;     // register write pulse
	logic                        ctl_sel;    // which register
	logic [7:0]                  ctl_wdata;  // register write data
	logic [7:0]                  timing_reg; // flash_read_timing_ctrl readback
	logic [7:0]                  cache_reg;  // cache_control_reg readback
	// device end
	modport dev (
		input  req, req_addr, ctl_wr, ctl_sel, ctl_wdata,
		output stall, resp_valid, resp_data, timing_reg, cache_reg
	);
	// core and software end
	modport host (
		output req, req_addr, ctl_wr, ctl_sel, ctl_wdata,
		input  stall, resp_valid, resp_data, timing_reg, cache_reg
	);
endinterface : flc_link_if

//--- logic/flc_core_side.sv
// flc_core_side: core fetch port and read-time update sequencer over avalon
module flc_core_side (
	input  wire logic        clock_in,
	input  wire logic        srst_in,
	flc_link_if.host         link,
	input  wire logic [1:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic [1:0]       clk_limit_out
);
	flc_pkg::flc_seq_state_t     sq_q, sq_d;     // update sequence
	logic [1:0]                  tgt_q, tgt_d;   // requested clock code
	logic [1:0]                  lim_q, lim_d;   // allowed clock code
	logic [2:0]                  csw_q, csw_d;   // software cache enables
	logic                        wr_q, wr_d;     // link register write
	logic                        sel_q, sel_d;
	logic [7:0]                  wd_q, wd_d;
	logic                        pend_q, pend_d; // fetch not yet taken
	logic                        out_q, out_d;   // fetch awaiting answer
	logic                        done_q, done_d; // answer present
	logic [7:0]                  dat_q, dat_d;
	logic [flc_pkg::ADDR_W-1:0]  adr_q, adr_d;
	logic                        wr_ok;          // avalon write accepted

	// writes stall while the matching resource is busy; reads never do
	always_comb begin
		avs_waitrequest_out = 1'b0;
		if (avs_write_in) begin
			if (avs_address_in == flc_pkg::AV_FETCH) begin
				avs_waitrequest_out = pend_q || out_q;
			end else begin
				avs_waitrequest_out = (sq_q != flc_pkg::SQ_IDLE);
			end
		end
	end
	assign wr_ok = avs_write_in && !avs_waitrequest_out;

	// read data mux; unmapped word reads zero
	always_comb begin
		case (avs_address_in)
			flc_pkg::AV_FETCH: avs_readdata_out = {22'h00_0000, pend_q || out_q,
				done_q, dat_q};
			flc_pkg::AV_CLOCK: avs_readdata_out = {16'h0000, link.timing_reg, 5'h00,
				sq_q != flc_pkg::SQ_IDLE, lim_q};
			flc_pkg::AV_CACHE: avs_readdata_out = {24'h00_0000, link.cache_reg};
			default:           avs_readdata_out = 32'h0000_0000;
		endcase
		// no read in progress: bus shows zero
		if (!avs_read_in) begin
			avs_readdata_out = 32'h0000_0000;
		end
	end

	// next state for fetches, software writes and the update sequence
	always_comb begin
		sq_d   = sq_q;
		tgt_d  = tgt_q;
		lim_d  = lim_q;
		csw_d  = csw_q;
		wr_d   = 1'b0;
		sel_d  = sel_q;
		wd_d   = wd_q;
		pend_d = pend_q;
		out_d  = out_q;
		done_d = done_q;
		dat_d  = dat_q;
		adr_d  = adr_q;
		// fetch handed over once the device is not stalled
		if (pend_q && !link.stall) begin
			pend_d = 1'b0;
			out_d  = 1'b1;
		end
		if (link.resp_valid && out_q) begin
			out_d  = 1'b0;
			done_d = 1'b1;
			dat_d  = link.resp_data;
		end
		if (wr_ok && avs_address_in == flc_pkg::AV_FETCH && (&avs_byteenable_in[1:0])) begin
			adr_d  = avs_writedata_in[flc_pkg::ADDR_W-1:0];
			pend_d = 1'b1;
			done_d = 1'b0;
		end
		if (wr_ok && avs_address_in == flc_pkg::AV_CACHE && avs_byteenable_in[0]) begin
			csw_d = avs_writedata_in[flc_pkg::CC_WREN:flc_pkg::CC_PFEN];
			wr_d  = 1'b1;
			sel_d = flc_pkg::SEL_CACHE;
			wd_d  = {csw_d, 5'h00};
		end
		case (sq_q)
			flc_pkg::SQ_IDLE: begin
				if (wr_ok && avs_address_in == flc_pkg::AV_CLOCK && avs_byteenable_in[0]) begin
					tgt_d = avs_writedata_in[1:0];
					sq_d  = flc_pkg::SQ_DROP;
				end
			end
			flc_pkg::SQ_DROP: begin
				lim_d = flc_pkg::RT_MIN;
				sq_d  = flc_pkg::SQ_OFF;
			end
			flc_pkg::SQ_OFF: begin
				wr_d  = 1'b1;
				sel_d = flc_pkg::SEL_CACHE;
				wd_d  = 8'h00;
				sq_d  = flc_pkg::SQ_SET;
			end
			flc_pkg::SQ_SET: begin
				wr_d  = 1'b1;
				sel_d = flc_pkg::SEL_TIMING;
				wd_d  = {2'b00, tgt_q, 4'h0};
				sq_d  = flc_pkg::SQ_ON;
			end
			flc_pkg::SQ_ON: begin
				wr_d  = 1'b1;
				sel_d = flc_pkg::SEL_CACHE;
				wd_d  = {csw_q, 5'h00};
				lim_d = tgt_q;
				sq_d  = flc_pkg::SQ_IDLE;
			end
			default: sq_d = flc_pkg::SQ_IDLE;
		endcase
	end

	// register everything
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			sq_q   <= flc_pkg::SQ_IDLE;
			tgt_q  <= flc_pkg::RT_RST;
			lim_q  <= flc_pkg::RT_RST;
			csw_q  <= flc_pkg::CC_RST;
			wr_q   <= 1'b0;
			sel_q  <= flc_pkg::SEL_TIMING;
			wd_q   <= 8'h00;
			pend_q <= 1'b0;
			out_q  <= 1'b0;
			done_q <= 1'b0;
			dat_q  <= 8'h00;
			adr_q  <= '0;
		end else begin
			sq_q   <= sq_d;
			tgt_q  <= tgt_d;
			lim_q  <= lim_d;
			csw_q  <= csw_d;
			wr_q   <= wr_d;
			sel_q  <= sel_d;
			wd_q   <= wd_d;
			pend_q <= pend_d;
			out_q  <= out_d;
			done_q <= done_d;
			dat_q  <= dat_d;
			adr_q  <= adr_d;
		end
	end

	assign link.req       = pend_q;
	assign link.req_addr  = adr_q;
	assign link.ctl_wr    = wr_q;
	assign link.ctl_sel   = sel_q;
	assign link.ctl_wdata = wd_q;
	assign clk_limit_out  = lim_q;
endmodule : flc_core_side

//--- test/flc_link_sva.sv
// flc_link_sva: assertions on the link between both ends and the flash strobe
module flc_link_sva (
	input wire logic        clock_in,
	input wire logic        srst_in,
	input wire logic        req,
	input wire logic        stall,
	input wire logic        resp_valid,
	input wire logic        ctl_wr,
	input wire logic        ctl_sel,
	input wire logic [7:0]  ctl_wdata,
	input wire logic [7:0]  timing_reg,
	input wire logic [7:0]  cache_reg,
	input wire logic        flash_strobe_out,
	input wire logic [12:0] flash_word_addr_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);
	logic        on_q;  // strobe seen last cycle
	logic [12:0] adr_q; // word under read last cycle
	logic [2:0]  run_q; // strobe cycles of this access so far
	logic [1:0]  rt_q;  // read time latched at access start
	logic [1:0]  rtp_q; // read time seen last cycle
	logic        fresh; // an access starts this cycle
	logic [2:0]  run_d;
	logic [1:0]  rt_d;
	// a new access starts when the strobe rises or the word moves on
	always_comb begin
		fresh = flash_strobe_out && (!on_q || flash_word_addr_out != adr_q);
		run_d = fresh ? 3'h1 : (flash_strobe_out ? run_q + 3'h1 : 3'h0);
		rt_d  = fresh ? rtp_q : rt_q;
	end
	// register the access tracking
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			on_q  <= 1'b0;
			adr_q <= 13'h0;
			run_q <= 3'h0;
			rt_q  <= 2'h0;
			rtp_q <= 2'h0;
		end else begin
			on_q  <= flash_strobe_out;
			adr_q <= flash_word_addr_out;
			run_q <= run_d;
			rt_q  <= rt_d;
			rtp_q <= timing_reg[5:4];
		end
	end
	chk_reset_value: assert property ($fell(srst_in) |-> timing_reg == 8'h00 && cache_reg == 8'he0)
		else $error("registers not at reset values");
	chk_unused_zero: assert property (timing_reg[7:6] == 2'h0 && timing_reg[3:0] == 4'h0)
		else $error("unused timing bits not zero");
	chk_timing_write: assert property (ctl_wr && ctl_sel == flc_pkg::SEL_TIMING |=>
		timing_reg == {2'h0, $past(ctl_wdata[5:4]), 4'h0}) else $error("read time not stored");
	chk_cache_write: assert property (ctl_wr && ctl_sel == flc_pkg::SEL_CACHE |=>
		cache_reg == {$past(ctl_wdata[7:5]), 5'h00}) else $error("cache control not stored");
	chk_update_order: assert property (ctl_wr && ctl_sel == flc_pkg::SEL_TIMING |->
		($past(ctl_wr) && $past(ctl_sel) == flc_pkg::SEL_CACHE && $past(ctl_wdata) == 8'h00)
		##1 (ctl_wr && ctl_sel == flc_pkg::SEL_CACHE)) else $error("read time update out of order");
	chk_strobe_len: assert property (flash_strobe_out |-> run_d <= {1'b0, rt_d} + 3'h1)
		else $error("flash strobe longer than read time");
	chk_stall_bound: assert property ($rose(stall) |-> ##[1:4] !stall)
		else $error("stall longer than four cycles");
	chk_stall_strobe: assert property (stall |-> flash_strobe_out)
		else $error("stall without flash strobe");
	chk_taken_answer: assert property (req && !stall |=> resp_valid || stall)
		else $error("taken fetch neither answered nor stalled");
	chk_stall_ends: assert property ($fell(stall) |-> resp_valid)
		else $error("stall ended without answer");
	chk_pf_stop: assert property ($rose(flash_strobe_out) && !cache_reg[5] &&
		!$past(cache_reg[5]) |-> $past(req) && !$past(stall)) else $error("prefetch while disabled");
endmodule : flc_link_sva

//--- test/tb_top.sv
// tb_top: both ends joined by the link, core side driven over avalon
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_in = 1'b0;        // 20 MHz system clock
	logic        srst_in  = 1'b1;        // sync reset, high
	logic [1:0]  av_addr  = 2'h0;        // avalon word index
	logic        av_rd    = 1'b0;
	logic        av_wr    = 1'b0;
	logic [31:0] av_wdata = 32'h0000_0000;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic [1:0]  clk_limit;
	logic        fl_strobe;
	logic [12:0] fl_addr;
	logic [31:0] fl_data;
	logic [2:0]  cc       = 3'h7;        // software cache setting
	integer      seed     = 32'h416f_ec0e;
	int          errors   = 0;
	int          checks_done = 0;
	int          cyc      = 0;
	int          t0       = 0;
	int          last_lat = 0;           // cycles from taken request to answer
	bit          pend     = 1'b0;
	bit          seen [8192];            // words that may sit in cache or prefetch
	flc_link_if link ();
	// flash content: the four bytes together tell the word apart
	function automatic logic [31:0] fl_word(input logic [12:0] w);
		return {w[12:5] ^ 8'h96, w[7:0], ~w[7:0], w[4:0], 3'h3};
	endfunction : fl_word
	// a word that is surely a miss
	function automatic logic [12:0] fresh();
		logic [12:0] w;
		do w = 13'($random(seed)); while (seen[w] || seen[w + 13'h1]);
		return w;
	endfunction : fresh
	// flash model: outside the strobe the bus shows the inverse pattern
	assign fl_data = fl_strobe ? fl_word(fl_addr) : ~fl_word(fl_addr);
	always #25 clock_in = ~clock_in;
	flc_fetch_cache u_flc_fetch_cache (.clock_in(clock_in), .srst_in(srst_in), .link(link),
		.flash_strobe_out(fl_strobe), .flash_word_addr_out(fl_addr), .flash_data_in(fl_data));
	flc_core_side u_flc_core_side (.clock_in(clock_in), .srst_in(srst_in), .link(link),
		.avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
		.avs_writedata_in(av_wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(av_rdata),
		.avs_waitrequest_out(av_wait), .clk_limit_out(clk_limit));
	flc_link_sva u_flc_link_sva (.clock_in(clock_in), .srst_in(srst_in), .req(link.req),
		.stall(link.stall), .resp_valid(link.resp_valid), .ctl_wr(link.ctl_wr),
		.ctl_sel(link.ctl_sel), .ctl_wdata(link.ctl_wdata), .timing_reg(link.timing_reg),
		.cache_reg(link.cache_reg), .flash_strobe_out(fl_strobe), .flash_word_addr_out(fl_addr));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	// avalon write, held until waitrequest is low at an edge
	task automatic av_write(input logic [1:0] i, input logic [31:0] d);
		av_addr  <= i;
		av_wdata <= d;
		av_wr    <= 1'b1;
		do @(posedge clock_in); while (av_wait !== 1'b0);
		av_wr <= 1'b0;
		@(posedge clock_in);
	endtask : av_write
	task automatic av_read(input logic [1:0] i, output logic [31:0] d);
		av_addr <= i;
		av_rd   <= 1'b1;
		do @(posedge clock_in); while (av_wait !== 1'b0);
		d = av_rdata;
		av_rd <= 1'b0;
		@(posedge clock_in);
	endtask : av_read
	task automatic do_reset();
		srst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		@(posedge clock_in);
		cc = 3'h7;
	endtask : do_reset
	// fetch one byte; lat above zero is the expected request-to-answer time
	task automatic fetch(input logic [12:0] w, input logic [1:0] o, input int lat);
		logic [31:0] r;
		int          n;
		repeat (4) @(posedge clock_in);
		av_write(flc_pkg::AV_FETCH, 32'({w, o}));
		n = 0;
		do begin
			av_read(flc_pkg::AV_FETCH, r);
			n++;
		end while (!(r[flc_pkg::ST_DONE] === 1'b1 && r[flc_pkg::ST_BUSY] === 1'b0) && n < 20);
		check("fetch done", 32'h0000_0001, 32'(r[flc_pkg::ST_DONE]));
		check("fetch byte", 32'(8'(fl_word(w) >> {o, 3'h0})), 32'(r[7:0]));
		if (lat > 0) check("fetch latency", 32'(lat), 32'(last_lat));
		seen[w] = 1'b1;
		seen[w + 13'h1] = 1'b1;
		seen[w + 13'h2] = 1'b1;
	endtask : fetch
	task automatic set_rt(input logic [1:0] t);
		logic [31:0] r;
		int          n;
		av_write(flc_pkg::AV_CLOCK, {30'($random(seed)), t});
		n = 0;
		do begin
			av_read(flc_pkg::AV_CLOCK, r);
			n++;
		end while (r[flc_pkg::CK_BUSY] !== 1'b0 && n < 20);
		repeat (2) @(posedge clock_in);
		check("clock limit", 32'(t), 32'(clk_limit));
		check("timing readback", 32'({4'h0, t, 4'h0}), 32'(r[15:8]));
		check("cache restored", 32'({cc, 5'h00}), 32'(link.cache_reg));
	endtask : set_rt
	task automatic set_cc(input logic [2:0] c);
		cc = c;
		av_write(flc_pkg::AV_CACHE, 32'({c, 5'h00}));
		repeat (2) @(posedge clock_in);
		check("cache reg", 32'({c, 5'h00}), 32'(link.cache_reg));
	endtask : set_cc
	// latency monitor and run limit
	always @(posedge clock_in) begin
		cyc++;
		if (link.req === 1'b1 && link.stall === 1'b0 && !pend) begin
			t0 = cyc;
			pend = 1'b1;
		end
		if (link.resp_valid === 1'b1) begin
			last_lat = cyc - t0;
			pend = 1'b0;
		end
		if (cyc == 30000) begin
			errors++;
			results();
		end
	end
	initial begin
		logic [31:0] r;
		logic [12:0] a;
		logic [12:0] b;
		do_reset();
		check("reset timing", 32'h0000_0000, 32'(link.timing_reg));
		check("reset cache", 32'h0000_00e0, 32'(link.cache_reg));
		check("reset limit", 32'h0000_0000, 32'(clk_limit));
		fetch(fresh(), 2'h1, 2);
		$display("test reset done");
		for (int t = 0; t < 4; t++) begin
			set_rt(2'(t));
			a = fresh();
			fetch(a, 2'(t), t + 2);
			fetch(a, 2'(3 - t), 1);
			fetch(a + 13'h1, 2'h0, 1);
		end
		$display("test read time done");
		for (int c = 0; c < 8; c++) begin
			set_cc(3'(c));
			a = fresh();
			fetch(a, 2'h2, 5);
			b = fresh();
			fetch(b, 2'h3, 5);
			fetch(b + 13'h1, 2'h0, cc[0] ? 1 : 5);
			fetch(a, 2'h1, (cc[2] && cc[1]) ? 1 : 5);
		end
		set_cc(3'h7);
		$display("test cache settings done");
		for (int i = 0; i < 24; i++) fetch(13'($random(seed)), 2'($random(seed)), 0);
		$display("test random fetch done");
		av_write(2'h3, $random(seed));
		av_read(2'h3, r);
		check("unmapped read", 32'h0000_0000, r);
		check("timing kept", 32'h0000_0030, 32'(link.timing_reg));
		$display("test unmapped done");
		do_reset();
		check("rereset timing", 32'h0000_0000, 32'(link.timing_reg));
		fetch(fresh(), 2'h0, 2);
		$display("test second reset done");
		results();
	end
endmodule : tb_top
